// File: shared/sfsr_pkg.sv
// constants and types of the switch fault status bank
package sfsr_pkg;
   localparam int NCH = 5;
   localparam int WORD_W = 16;
   localparam int SYNC_W = 75;
   localparam logic [3:0] ADDR_INIT0 = 4'h0;
   localparam logic [3:0] ADDR_OVERVIEW = 4'h1;
   localparam logic [3:0] ADDR_CH1 = 4'h2;
   localparam logic [3:0] ADDR_CH5 = 4'h6;
   localparam logic [3:0] ADDR_DEVICE = 4'h7;
   localparam logic [3:0] ADDR_PINS = 4'h8;
   localparam logic [3:0] ADDR_ACM_CTRL = 4'hA;
   localparam logic [3:0] SEL_RESET = 4'h0;
   localparam logic [2:0] FB_TEMP = 3'h5;
   localparam logic [2:0] FB_SUPPLY = 3'h6;
   localparam logic [2:0] FB_OFF = 3'h7;
   localparam logic [4:0] FRAME_BITS = 5'h10;
   localparam logic [4:0] CNT_MAX = 5'h1F;
   localparam int CMD_ADDR_LSB = 12;
   localparam int CMD_SEL_LSB = 0;
   localparam int CMD_FB_LSB = 4;
   localparam int CMD_ACM_LSB = 0;
   localparam int FM_BIT = 11;
   typedef enum logic [1:0] {
      LINK_IDLE = 2'b01,
      LINK_SHIFT = 2'b10
   } sfsr_link_t;
endpackage

// File: rtl/sfsr_status_bank.sv
// status words, serial readback and feedback gating of the switch
`timescale 1ns/10ps
module sfsr_status_bank (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   input wire logic fail_mode_indicator,
   input wire logic sleep_mode,
   input wire logic supply_undervoltage_flag,
   input wire logic supply_overvoltage_flag,
   input wire logic charge_pump_fault_flag,
   input wire logic pwm_clock_fault_flag,
   input wire logic test_mode_entry_flag,
   input wire logic limp_home_input,
   input wire logic [3:0] deglitched_input_state,
   input wire logic [3:0] input_toggle,
   input wire logic [sfsr_pkg::NCH-1:0] half_supply_comparator,
   input wire logic [sfsr_pkg::NCH-1:0] oc_event,
   input wire logic [3*sfsr_pkg::NCH-1:0] oc_stage_code,
   input wire logic [sfsr_pkg::NCH-1:0] overtemp_shutdown_flag,
   input wire logic [sfsr_pkg::NCH-1:0] overtemp_warning_flag,
   input wire logic [sfsr_pkg::NCH-1:0] openload_on_flag,
   input wire logic [sfsr_pkg::NCH-1:0] openload_off_flag,
   input wire logic [sfsr_pkg::NCH-1:0] inrush_high_current_window,
   input wire logic [sfsr_pkg::NCH-1:0] output_on_phase,
   input wire logic sense_sample_strobe,
   output logic analog_feedback_enable,
   output logic [2:0] feedback_source_select,
   output logic [sfsr_pkg::NCH-1:0] sense_mode_active,
   output logic [sfsr_pkg::NCH-1:0] offset_sign
);
   import sfsr_pkg::*;

   // every pin input passes two flops as one vector
   // the select line idles high, so its flops wake high: no false frame
   localparam logic [SYNC_W-1:0] SYNC_IDLE = {1'b0, 1'b1,
      {(SYNC_W-2){1'b0}}};
   logic [SYNC_W-1:0] sync1_q, sync2_q;
   logic sclk_s, cs_n_s, mosi_s, fm_s, sleep_s, uv_s, ov_s, cp_s, pwm_clock_fault_flag_s;
   logic tm_s, limp_s, strobe_s;
   logic [3:0] din_s, tog_s;
   logic [NCH-1:0] cmp_s, oce_s, ots_s, otw_s, olon_s, oloff_s;
   logic [NCH-1:0] inrush_s, onph_s;
   logic [3*NCH-1:0] stage_s;
   wire [SYNC_W-1:0] raw_in = {spi_sclk, spi_cs_n, spi_mosi,
      fail_mode_indicator, sleep_mode, supply_undervoltage_flag,
      supply_overvoltage_flag, charge_pump_fault_flag, pwm_clock_fault_flag,
      test_mode_entry_flag, limp_home_input, deglitched_input_state,
      input_toggle, half_supply_comparator, oc_event, oc_stage_code,
      overtemp_shutdown_flag, overtemp_warning_flag, openload_on_flag,
      openload_off_flag, inrush_high_current_window, output_on_phase,
      sense_sample_strobe};
   assign {sclk_s, cs_n_s, mosi_s, fm_s, sleep_s, uv_s, ov_s, cp_s, pwm_clock_fault_flag_s,
      tm_s, limp_s, din_s, tog_s, cmp_s, oce_s, stage_s, ots_s, otw_s,
      olon_s, oloff_s, inrush_s, onph_s, strobe_s} = sync2_q;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sync1_q <= SYNC_IDLE;
         sync2_q <= SYNC_IDLE;
      end else begin
         sync1_q <= raw_in;
         sync2_q <= sync1_q;
      end
   end

   // edge history of synchronised link and event lines
   logic sclk_q, cs_n_q, strobe_q;
   logic [NCH-1:0] oce_q;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sclk_q <= 1'b0;
         cs_n_q <= 1'b1;
         strobe_q <= 1'b0;
         oce_q <= '0;
      end else begin
         sclk_q <= sclk_s;
         cs_n_q <= cs_n_s;
         strobe_q <= strobe_s;
         oce_q <= oce_s;
      end
   end
   wire sclk_rise = sclk_s & ~sclk_q;
   wire sclk_fall = ~sclk_s & sclk_q;
   wire cs_fall = ~cs_n_s & cs_n_q;
   wire cs_rise = cs_n_s & ~cs_n_q;
   wire strobe_rise = strobe_s & ~strobe_q;
   wire [NCH-1:0] oce_rise = oce_s & ~oce_q;

   // serial frame engine
   sfsr_link_t state_q, state_d;
   logic [WORD_W-1:0] tx_q, rx_q;
   logic [4:0] cnt_q;
   logic [3:0] ret_sel_q, sel_q;
   logic [2:0] fbsel_q;
   logic [NCH-1:0] acm_en_q;
   logic miso_q;
   logic [WORD_W-1:0] so_word;
   wire frame_end = (state_q == LINK_SHIFT) & cs_rise;
   wire frame_ok = frame_end & (cnt_q == FRAME_BITS);
   wire frame_bad = frame_end & (cnt_q != FRAME_BITS);
   wire [3:0] cmd_addr = rx_q[CMD_ADDR_LSB +: 4];
   wire wr_init0 = frame_ok & (cmd_addr == ADDR_INIT0);
   wire wr_acm = frame_ok & (cmd_addr == ADDR_ACM_CTRL);
   wire rd_overview = frame_ok & ((ret_sel_q == ADDR_OVERVIEW) |
      (ret_sel_q == SEL_RESET));
   wire rd_device = frame_ok & (ret_sel_q == ADDR_DEVICE);

   always_comb begin
      state_d = state_q;
      case (state_q)
         LINK_IDLE: begin
            if (cs_fall) begin
               state_d = LINK_SHIFT;
            end
         end
         LINK_SHIFT: begin
            if (cs_rise) begin
               state_d = LINK_IDLE;
            end
         end
         default: begin
            state_d = LINK_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_q <= LINK_IDLE;
         tx_q <= '0;
         rx_q <= '0;
         cnt_q <= '0;
         ret_sel_q <= SEL_RESET;
         miso_q <= 1'b0;
      end else begin
         state_q <= state_d;
         if (state_q == LINK_IDLE && cs_fall) begin
            tx_q <= so_word;
            miso_q <= so_word[WORD_W-1];
            ret_sel_q <= sel_q;
            cnt_q <= '0;
         end else if (state_q == LINK_SHIFT) begin
            if (sclk_rise) begin
               rx_q <= {rx_q[WORD_W-2:0], mosi_s};
               if (cnt_q != CNT_MAX) begin
                  cnt_q <= cnt_q + 5'h01;
               end
            end
            if (sclk_fall) begin
               tx_q <= {tx_q[WORD_W-2:0], 1'b0};
               miso_q <= tx_q[WORD_W-2];
            end
         end
      end
   end

   // configuration written by the host
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sel_q <= SEL_RESET;
         fbsel_q <= FB_OFF;
         acm_en_q <= '0;
      end else begin
         if (wr_init0) begin
            sel_q <= rx_q[CMD_SEL_LSB +: 4];
            fbsel_q <= rx_q[CMD_FB_LSB +: 3];
         end
         if (fm_s) begin
            acm_en_q <= '0;
         end else if (wr_acm) begin
            acm_en_q <= rx_q[CMD_ACM_LSB +: NCH];
         end
      end
   end

   // latched channel faults, set wins over read clear
   logic [NCH-1:0] ots_q, otw_q, olon_q, oloff_q, qsf;
   logic [3*NCH-1:0] oc_q;
   logic [WORD_W-1:0] ch_word [NCH];
   logic [2:0] glob;
   genvar i;
   generate
      for (i = 0; i < NCH; i++) begin : g_ch
         wire clr = frame_ok & (ret_sel_q == 4'(ADDR_CH1 + i));
         always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
               ots_q[i] <= 1'b0;
               otw_q[i] <= 1'b0;
               olon_q[i] <= 1'b0;
               oloff_q[i] <= 1'b0;
               oc_q[3*i +: 3] <= 3'h0;
            end else begin
               ots_q[i] <= ots_s[i] | (ots_q[i] & ~clr);
               otw_q[i] <= otw_s[i] | (otw_q[i] & ~clr);
               olon_q[i] <= olon_s[i] | (olon_q[i] & ~clr);
               oloff_q[i] <= oloff_s[i] | (oloff_q[i] & ~clr);
               if (oce_rise[i]) begin
                  oc_q[3*i +: 3] <= stage_s[3*i +: 3];
               end else if (clr) begin
                  oc_q[3*i +: 3] <= 3'h0;
               end
            end
         end
         assign qsf[i] = (|oc_q[3*i +: 3]) | otw_q[i] | ots_q[i] |
            olon_q[i] | oloff_q[i];
         assign ch_word[i] = {4'(ADDR_CH1 + i), fm_s, glob, 1'b0, ots_q[i],
            otw_q[i], oc_q[3*i +: 3], olon_q[i], oloff_q[i]};
      end
   endgenerate

   // latched device faults
   logic cpf_q, uvf_q, ovf_q, tmf_q, pwm_clock_fault_flag_q, serial_frame_fault_flag_q, rcf_q;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cpf_q <= 1'b0;
         uvf_q <= 1'b0;
         ovf_q <= 1'b0;
         tmf_q <= 1'b0;
         pwm_clock_fault_flag_q <= 1'b0;
         serial_frame_fault_flag_q <= 1'b0;
         rcf_q <= 1'b1;
      end else begin
         cpf_q <= cp_s | (cpf_q & ~rd_overview);
         uvf_q <= uv_s | (uvf_q & ~rd_device);
         ovf_q <= ov_s | (ovf_q & ~rd_device);
         tmf_q <= tm_s | (tmf_q & ~rd_device);
         pwm_clock_fault_flag_q <= pwm_clock_fault_flag_s | (pwm_clock_fault_flag_q & ~rd_device);
         serial_frame_fault_flag_q <= frame_bad | (serial_frame_fault_flag_q & ~rd_device);
         rcf_q <= rcf_q & ~rd_device;
      end
   end

   // global summaries and returned words
   wire device_fault_summary = rcf_q | uvf_q | ovf_q | cpf_q | pwm_clock_fault_flag_q | tmf_q;
   wire overload_summary_flag = (|oc_q) | (|ots_q);
   wire openload_summary_flag = (|olon_q) | (|oloff_q);
   assign glob = {device_fault_summary, overload_summary_flag, openload_summary_flag};
   wire [WORD_W-1:0] ov_word = {ADDR_OVERVIEW, fm_s, glob, cpf_q, rcf_q,
      pwm_clock_fault_flag_q, qsf};
   wire [WORD_W-1:0] dev_word = {ADDR_DEVICE, fm_s, glob, 3'h0, tmf_q,
      ovf_q, uvf_q, serial_frame_fault_flag_q, limp_s};
   // output levels masked to zero while undervoltage makes them meaningless
   wire [NCH-1:0] out_lvl = uv_s ? '0 : cmp_s;
   wire [WORD_W-1:0] pin_word = {ADDR_PINS, fm_s, 1'b0, |tog_s, din_s,
      out_lvl};
   wire sel_ch = (sel_q >= ADDR_CH1) & (sel_q <= ADDR_CH5);
   wire [2:0] ch_idx = 3'(sel_q - ADDR_CH1);
   assign so_word = sel_ch ? ch_word[ch_idx] :
      (sel_q == ADDR_DEVICE) ? dev_word :
      (sel_q == ADDR_PINS) ? pin_word : ov_word;

   // analog feedback gating and offset chopping
   logic fb_en_q;
   logic [2:0] fb_out_q;
   logic [NCH-1:0] acm_act_q, sign_q;
   wire normal = ~fm_s & ~sleep_s;
   wire fb_is_ch = fbsel_q < FB_TEMP;
   wire cur_ok = fb_is_ch & ~inrush_s[fbsel_q] & onph_s[fbsel_q];
   wire fb_volt = (fbsel_q == FB_TEMP) | (fbsel_q == FB_SUPPLY);
   wire fb_en_d = normal & (cur_ok | fb_volt);
   wire [NCH-1:0] acm_act_d = acm_en_q & ~{NCH{fm_s}};
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         fb_en_q <= 1'b0;
         fb_out_q <= FB_OFF;
         acm_act_q <= '0;
         sign_q <= '0;
      end else begin
         fb_en_q <= fb_en_d;
         fb_out_q <= normal ? fbsel_q : FB_OFF;
         acm_act_q <= acm_act_d;
         if (strobe_rise) begin
            sign_q <= (sign_q ^ acm_act_q) & acm_act_d;
         end else begin
            sign_q <= sign_q & acm_act_d;
         end
      end
   end

   assign spi_miso = miso_q;
   assign analog_feedback_enable = fb_en_q;
   assign feedback_source_select = fb_out_q;
   assign sense_mode_active = acm_act_q;
   assign offset_sign = sign_q;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);

   a_default_overview: assert property (
      (state_q == LINK_IDLE && cs_fall && sel_q == SEL_RESET)
      |=> tx_q[WORD_W-1 -: 4] == ADDR_OVERVIEW)
      else $error("default readback is not the overview word");
   a_fm_in_word: assert property (
      (state_q == LINK_IDLE && cs_fall) |=> tx_q[FM_BIT] == $past(fm_s))
      else $error("fail mode bit wrong in returned word");
   a_miso_msb: assert property (
      (state_q == LINK_IDLE && cs_fall) |=> spi_miso == tx_q[WORD_W-1])
      else $error("first serial bit is not the word msb");
   a_select_write: assert property (
      (wr_init0) |=> sel_q == $past(rx_q[CMD_SEL_LSB +: 4]))
      else $error("readback select not taken from frame");
   a_pump_hold: assert property (
      (cpf_q && cp_s) |=> cpf_q)
      else $error("pump fault cleared while condition present");
   a_pump_clear: assert property (
      (rd_overview && !cp_s) |=> !cpf_q)
      else $error("pump fault not cleared by overview read");
   a_oc_overwrite: assert property (
      oce_rise[0] |=> oc_q[2:0] == $past(stage_s[2:0]))
      else $error("newest overcurrent stage not stored");
   a_fail_fb_off: assert property (
      fm_s |=> !analog_feedback_enable ##0 feedback_source_select == FB_OFF)
      else $error("feedback alive in fail mode");
   a_fail_acm_off: assert property (
      fm_s [*2] |-> sense_mode_active == '0 && acm_en_q == '0)
      else $error("chopping mode not forced off in fail mode");
   a_chop_toggle: assert property (
      (strobe_rise && acm_act_q[0] && acm_act_d[0])
      |=> offset_sign[0] != $past(offset_sign[0]))
      else $error("offset sign not flipped on strobe edge");
   a_limp_live: assert property (
      (state_q == LINK_IDLE && cs_fall && sel_q == ADDR_DEVICE)
      |=> tx_q[0] == $past(limp_s))
      else $error("limp bit not live in device word");
   a_rcf_dev_clear: assert property (
      rd_device |=> !rcf_q)
      else $error("registers cleared flag kept after device read");
   a_chan_clear: assert property (
      (frame_ok && ret_sel_q == ADDR_CH1 && !oce_rise[0]) |=> oc_q[2:0] == 3'h0)
      else $error("channel read did not clear stage bits");
   a_feedback_sel: assert property (
      normal |=> feedback_source_select == $past(fbsel_q))
      else $error("feedback source not passed in normal mode");

   c_good_frame: cover property (frame_ok);
   c_bad_frame: cover property (frame_bad);
   c_channel_read: cover property (frame_ok && ret_sel_q == ADDR_CH1);
   c_chop: cover property (strobe_rise && acm_act_q != '0);
   c_device_read: cover property (rd_device);
endmodule

// File: bench/sfsr_host_model.sv
// host side serial master that runs one 16-bit command frame on request
`timescale 1ns/10ps
module sfsr_host_model (
   input wire logic clk_sys,
   input wire logic req,
   input wire logic [15:0] cmd,
   output logic done,
   output logic [15:0] rx,
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_mosi,
   input wire logic spi_miso
);
   logic [15:0] c;
   logic [15:0] shift;
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   initial begin
      done = 1'b0;
      rx = 16'h0000;
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
      shift = 16'h0000;
      forever begin
         @(posedge clk_sys);
         if (req) begin
            c = cmd;
            spi_cs_n <= 1'b0;
            spi_mosi <= c[15];
            tick(4);
            for (int i = 15; i >= 0; i--) begin
               spi_sclk <= 1'b1;
               shift[i] = spi_miso;
               tick(4);
               spi_sclk <= 1'b0;
               if (i > 0) spi_mosi <= c[i-1];
               tick(4);
            end
            spi_cs_n <= 1'b1;
            // a released data line shows no stale level
            spi_mosi <= ~spi_mosi;
            tick(8);
            rx <= shift;
            done <= 1'b1;
            tick(1);
            done <= 1'b0;
         end
      end
   end
endmodule

// File: bench/sfsr_status_bank_test.sv
// self-checking bench of the switch fault status bank
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin \
   total_checks++; \
   if ((got) !== (ex)) begin \
      bad_count++; \
      $display("wrong value %s exp %h got %h", nm, ex, got); \
   end \
end
module switch_fault_status_reporting_test;
   logic clk_sys = 1'b0, resetn, req, done, fm, sleep, cp, lp, strobe;
   logic sclk, cs_n, mosi, miso, fbe, analog_feedback_enable;
   logic [15:0] cmd, rx;
   logic [16:0] note;
   logic [3:0] fl, din, tog, sel;
   logic [4:0] hsc, oc_ev, ots, otw, olon, oloff, inrush, onph, k, sma, osg;
   logic [14:0] oc_code;
   logic [2:0] a, b, s, fss;
   logic [16:0] notes[$];
   int bad_count = 0;
   int total_checks = 0;
   always #12.5 clk_sys = ~clk_sys;
   sfsr_host_model sfsr_host_model_inst (.clk_sys(clk_sys), .req(req),
      .cmd(cmd), .done(done), .rx(rx), .spi_sclk(sclk), .spi_cs_n(cs_n),
      .spi_mosi(mosi), .spi_miso(miso));
   sfsr_status_bank sfsr_status_bank_inst (.clk_sys(clk_sys),
      .resetn(resetn), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
      .spi_miso(miso), .fail_mode_indicator(fm), .sleep_mode(sleep),
      .supply_undervoltage_flag(fl[0]), .supply_overvoltage_flag(fl[1]),
      .test_mode_entry_flag(fl[2]), .pwm_clock_fault_flag(fl[3]),
      .charge_pump_fault_flag(cp), .limp_home_input(lp),
      .deglitched_input_state(din), .input_toggle(tog),
      .half_supply_comparator(hsc), .oc_event(oc_ev),
      .oc_stage_code(oc_code), .overtemp_shutdown_flag(ots),
      .overtemp_warning_flag(otw), .openload_on_flag(olon),
      .openload_off_flag(oloff), .inrush_high_current_window(inrush),
      .output_on_phase(onph), .sense_sample_strobe(strobe),
      .analog_feedback_enable(analog_feedback_enable),
      .feedback_source_select(fss), .sense_mode_active(sma),
      .offset_sign(osg));
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic end_sim();
      if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic frame(input logic [15:0] c, input bit chk,
                        input logic [15:0] e);
      int n;
      notes.push_back({chk, e});
      @(posedge clk_sys);
      req <= 1'b1;
      cmd <= c;
      @(posedge clk_sys);
      req <= 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 400) begin
         @(posedge clk_sys);
         n++;
      end
      if (n >= 400) bad_count++;
   endtask
   task automatic oc_hit(input int c, input logic [2:0] v);
      oc_code[3*c+:3] <= v;
      oc_ev[c] <= 1'b1;
      tick(6);
      oc_ev[c] <= 1'b0;
      tick(6);
   endtask
   function automatic logic [15:0] pinw();
      return {4'h8, fm, 1'b0, |tog, din, hsc};
   endfunction
   // result watcher: compares each returned word with the oldest note
   always @(posedge clk_sys) begin
      if (done === 1'b1) begin
         note = (notes.size() > 0) ? notes.pop_front() : {1'b1, 16'hXXXX};
         if (note[16]) `CHK("miso word", note[15:0], rx)
      end
   end
   initial begin
      #1000000;
      bad_count++;
      end_sim();
   end
   initial begin
      {resetn, req, fm, sleep, cp, strobe, fl, din, tog, hsc} = '0;
      {oc_ev, ots, otw, olon, oloff, inrush, onph, oc_code, cmd} = '0;
      void'($urandom(89));
      lp = 1'($urandom);
      tick(8);
      resetn <= 1'b1;
      tick(4);
      frame(16'h3000, 1, 16'h1440);
      frame(16'h0077, 1, 16'h1440);
      frame(16'h0077, 1, 16'h7400 | 16'(lp));
      frame(16'h0077, 1, 16'h7000 | 16'(lp));
      for (int i = 0; i < 4; i++) begin
         fl <= 4'(1 << i);
         tick(6);
         fl <= 4'h0;
         tick(6);
         k = (i < 3) ? 5'(4 << i) : 5'h00;
         frame(16'h0077, 1, 16'h7400 | 16'(k) | 16'(lp));
         frame(16'h0077, 1, 16'h7000 | 16'(lp));
      end
      cp <= 1'b1;
      tick(6);
      frame(16'h0070, 1, 16'h7400 | 16'(lp));
      frame(16'h0070, 1, 16'h1480);
      cp <= 1'b0;
      tick(6);
      frame(16'h0070, 1, 16'h1480);
      frame(16'h0070, 1, 16'h1000);
      for (int c = 0; c < 5; c++) begin
         a = 3'($urandom_range(1, 7));
         b = 3'($urandom_range(1, 7));
         oc_hit(c, a);
         oc_hit(c, b);
         k = 5'(1 << c);
         ots <= c[0] ? k : 5'h00;
         otw <= c[0] ? 5'h00 : k;
         olon <= c[1] ? k : 5'h00;
         oloff <= c[1] ? 5'h00 : k;
         tick(6);
         {ots, otw, olon, oloff} <= '0;
         tick(6);
         sel = 4'(c + 2);
         frame(16'h0070, 1, 16'h1300 | 16'(k));
         frame({12'h007, sel}, 1, 16'h1300 | 16'(k));
         frame({12'h007, sel}, 1, {sel, 4'h3, 1'b0, c[0], !c[0], b,
               c[1], !c[1]});
         frame(16'h0070, 1, {sel, 12'h000});
      end
      frame(16'h0078, 1, 16'h1000);
      for (int i = 0; i < 4; i++) begin
         {fm, din, tog, hsc} <= 14'($urandom);
         tick(6);
         frame(16'h0078, 1, pinw());
      end
      for (int i = 0; i < 8; i++) begin
         fm <= 1'b0;
         sleep <= 1'b0;
         tick(2);
         s = 3'($urandom_range(0, 6));
         frame({9'h000, s, 4'h8}, 1, pinw());
         fm <= ($urandom_range(0, 3) == 0);
         sleep <= ($urandom_range(0, 3) == 0);
         inrush <= 5'($urandom);
         onph <= 5'($urandom);
         tick(6);
         fbe = !fm && !sleep && (s > 4 || (!inrush[s] && onph[s]));
         `CHK("feedback enable", fbe, analog_feedback_enable)
         `CHK("feedback select", (!fm && !sleep) ? s : sfsr_pkg::FB_OFF, fss)
      end
      fm <= 1'b0;
      sleep <= 1'b0;
      tick(2);
      frame(16'hA01F, 1, pinw());
      tick(6);
      `CHK("sense mode", 5'h1F, sma)
      for (int i = 0; i < 2; i++) begin
         strobe <= 1'b1;
         tick(6);
         strobe <= 1'b0;
         tick(6);
         `CHK("offset sign", i ? 5'h00 : 5'h1F, osg)
      end
      fm <= 1'b1;
      tick(6);
      `CHK("sense mode", 5'h00, sma)
      fm <= 1'b0;
      tick(6);
      `CHK("sense mode", 5'h00, sma)
      fl <= 4'h4;
      tick(6);
      fl <= 4'h0;
      tick(6);
      frame(16'h0077, 1, pinw());
      frame(16'h0077, 1, 16'h7410 | 16'(lp));
      resetn <= 1'b0;
      tick(8);
      resetn <= 1'b1;
      tick(4);
      frame(16'h3000, 1, 16'h1440);
      tick(4);
      end_sim();
   end
endmodule
